/* fifo_dev_model.sv */
// behavioural model of two cascadable 9-bit fifo devices seen from the host pins
`timescale 1ns/100ps
module fifo_dev_model #(
	parameter int DEV_DEPTH = 4
) (
	input wire logic depth_mode_i,
	input wire logic clear_input_n_i,
	input wire logic chain_head_select_i,
	input wire logic write_strobe_n_i,
	input wire logic read_strobe_n_i,
	input wire logic [8:0] data_in_bus_i,
	output logic [8:0] data_out_bus_o,
	output logic [1:0] full_indicator_n_o,
	output logic [1:0] empty_indicator_n_o,
	output logic half_full_indicator_n_o
);
	logic [8:0] mem_q [2*DEV_DEPTH];
	logic [8:0] last_q = 9'h000;
	logic w_ok = 1'b0;
	logic r_ok = 1'b0;
	int wr_q = 0;
	int rd_q = 0;
	int lim;
	int cnt;
	int occ_lo;
	int occ_hi;
	// in depth mode the token passes at each device's last location, so the pair acts as one ring
	assign lim = depth_mode_i ? 2 * DEV_DEPTH : DEV_DEPTH;
	assign cnt = wr_q - rd_q;
	always @(negedge write_strobe_n_i) w_ok = (cnt < lim);
	always @(posedge write_strobe_n_i) begin
		if (w_ok && clear_input_n_i) begin
			mem_q[wr_q % lim] = data_in_bus_i;
			wr_q = wr_q + 1;
		end
		w_ok = 1'b0;
	end
	always @(negedge read_strobe_n_i) r_ok = (cnt > 0);
	always @(posedge read_strobe_n_i) begin
		if (r_ok && clear_input_n_i) begin
			last_q = mem_q[rd_q % lim];
			rd_q = rd_q + 1;
		end
		r_ok = 1'b0;
	end
	always @(negedge clear_input_n_i) begin
		wr_q = 0;
		rd_q = 0;
	end
	// replay only exists when the pin is not the chain-head select
	always @(negedge chain_head_select_i) if (!depth_mode_i) rd_q = 0;
	// released bus shows the inverse of the last word, never a stale copy
	assign data_out_bus_o = (!read_strobe_n_i && r_ok) ? mem_q[rd_q % lim] : ~last_q;
	// per-device fill, so each chained device reports its own flags
	always_comb begin
		int a;
		int b;
		a = 0;
		b = 0;
		for (int i = rd_q; i < wr_q; i++) begin
			if ((i % lim) < DEV_DEPTH) a++;
			else b++;
		end
		occ_lo = a;
		occ_hi = b;
	end
	assign full_indicator_n_o = depth_mode_i ? {occ_hi != DEV_DEPTH, occ_lo != DEV_DEPTH}
		: {1'b1, cnt != lim};
	assign empty_indicator_n_o = depth_mode_i ? {occ_hi != 0, occ_lo != 0}
		: {1'b1, cnt != 0};
	assign half_full_indicator_n_o = depth_mode_i || !(cnt > lim / 2);
endmodule // fifo_dev_model

/* fifo_host.sv */
// host controller driving the strobes of an asynchronous 9-bit fifo array
// Overview of operation
// - cascade devices when depth exceeds one device
// - first chain device holds chain-head select low
// - other chain devices hold chain-head select high
// - each token output feeds next token input
// - composite flags assert only when all assert
// - width mode ties controls, flags from one
// - two fifos may couple bidirectional systems
// - each new word needs fresh write pulse
`timescale 1ns/100ps
module fifo_host
	import fifo_host_pkg::*;
#(
	parameter int NDEV = 2,
	parameter int BUF_DEPTH = 16,
	parameter bit IS_FIRST = 1'b1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [1:0] mode_i,
	input wire logic clear_req_i,
	input wire logic replay_req_i,
	input wire logic wr_valid_i,
	input wire logic [DATA_W-1:0] wr_data_i,
	output logic wr_ready_o,
	output logic rd_valid_o,
	output logic [DATA_W-1:0] rd_data_o,
	input wire logic rd_ready_i,
	output logic busy_o,
	output logic full_o,
	output logic empty_o,
	output logic half_full_o,
	output logic clear_input_n_o,
	output logic chain_head_select_o,
	output logic write_strobe_n_o,
	output logic read_strobe_n_o,
	output logic [DATA_W-1:0] data_in_bus_o,
	input wire logic [DATA_W-1:0] data_out_bus_i,
	input wire logic [NDEV-1:0] full_indicator_n_i,
	input wire logic [NDEV-1:0] empty_indicator_n_i,
	input wire logic half_full_indicator_n_i
);
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_CLEAR = 7'h02,
		ST_REPLAY = 7'h04,
		ST_WRITE = 7'h08,
		ST_READ = 7'h10,
		ST_RECOVER = 7'h20,
		ST_HOLD = 7'h40
	} state_e;

	state_e state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic clear_pend_q;
	logic replay_pend_q;
	logic prefer_rd_q;
	logic [DATA_W-1:0] wr_data_q;
	logic [DATA_W-1:0] rd_data_q;
	logic rd_valid_q;

	// phase counters run down to zero, so a phase of n cycles loads n - 1
	function automatic logic [CNT_W-1:0] cyc_load(input int n);
		return CNT_W'(n - 1);
	endfunction

	word_stream_if #(.WIDTH(DATA_W)) in_s ();
	word_stream_if #(.WIDTH(DATA_W)) out_s ();

	assign in_s.valid = wr_valid_i;
	assign in_s.data = wr_data_i;
	assign wr_ready_o = in_s.ready;

	word_buffer #(
		.WIDTH(DATA_W),
		.DEPTH(BUF_DEPTH)
	) u_buffer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.push(in_s),
		.pop(out_s)
	);

	// the token chain is board wiring; depth mode treats the NDEV devices as one buffer
	wire depth_mode = (mode_i == MODE_DEPTH);
	// in depth mode the composite flag is low only when every device reports it low; in other modes device 0 alone sets it
	wire full_all_n = depth_mode ? (|full_indicator_n_i) : full_indicator_n_i[0];
	wire empty_all_n = depth_mode ? (|empty_indicator_n_i) : empty_indicator_n_i[0];
	wire cnt_done = (cnt_q == '0);
	wire can_wr = out_s.valid && full_all_n;
	// a word waits in rd_data_q until taken, so reads stall on back-pressure
	wire can_rd = empty_all_n && !rd_valid_q;
	wire do_wr = can_wr && (!can_rd || !prefer_rd_q);
	wire do_rd = can_rd && !do_wr;
	wire replay_ok = replay_pend_q && !depth_mode;
	wire wr_finish = (state_q == ST_WRITE) && cnt_done;
	wire rd_finish = (state_q == ST_READ) && cnt_done;
	wire take_clear = (state_q == ST_IDLE) && clear_pend_q;
	wire take_replay = (state_q == ST_IDLE) && !clear_pend_q && replay_ok;

	// buffer word leaves only on the rising write strobe, one word per pulse
	assign out_s.ready = wr_finish;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_done ? cnt_q : cnt_q - 1'b1;
		case (state_q)
			ST_IDLE: begin
				if (clear_pend_q) begin
					state_d = ST_CLEAR;
					cnt_d = cyc_load(CLEAR_LOW_CYC);
				end else if (replay_ok) begin
					state_d = ST_REPLAY;
					cnt_d = cyc_load(REPLAY_LOW_CYC);
				end else if (do_wr) begin
					state_d = ST_WRITE;
					cnt_d = cyc_load(WR_LOW_CYC);
				end else if (do_rd) begin
					state_d = ST_READ;
					cnt_d = cyc_load(ACCESS_CYC);
				end
			end
			ST_CLEAR, ST_REPLAY, ST_WRITE, ST_READ: begin
				if (cnt_done) begin
					state_d = ST_RECOVER;
					cnt_d = cyc_load(FLAG_REC_CYC);
				end
			end
			ST_RECOVER: begin
				// flags lag the strobe edge, so they are ignored until settled
				if (cnt_done) begin
					state_d = ST_HOLD;
				end
			end
			ST_HOLD: begin
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
				cnt_d = '0;
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// a request arriving in the taking cycle is kept, set wins over clear
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			clear_pend_q <= 1'b1;
			replay_pend_q <= 1'b0;
		end else begin
			clear_pend_q <= clear_req_i || (clear_pend_q && !take_clear);
			replay_pend_q <= (replay_req_i && !depth_mode)
				|| (replay_pend_q && !take_replay && !take_clear && !depth_mode);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prefer_rd_q <= 1'b0;
			wr_data_q <= '0;
		end else begin
			if (wr_finish) prefer_rd_q <= 1'b1;
			if (rd_finish) prefer_rd_q <= 1'b0;
			if (state_q == ST_IDLE && state_d == ST_WRITE) wr_data_q <= out_s.data;
		end
	end

	// word is sampled after access time while the read strobe is still low
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_valid_q <= 1'b0;
			rd_data_q <= '0;
		end else begin
			if (rd_finish) begin
				rd_valid_q <= 1'b1;
				rd_data_q <= data_out_bus_i;
			end else if (rd_ready_i) begin
				rd_valid_q <= 1'b0;
			end
		end
	end

	// strobes come straight from one-hot state bits, so they cannot glitch
	assign write_strobe_n_o = (state_q != ST_WRITE);
	assign read_strobe_n_o = (state_q != ST_READ);
	assign clear_input_n_o = (state_q != ST_CLEAR);
	// in a chain this pin marks the head; alone it is the replay strobe
	assign chain_head_select_o = depth_mode ? (IS_FIRST ? PIN_LOW : PIN_HIGH)
		: (state_q != ST_REPLAY);
	assign data_in_bus_o = wr_data_q;
	assign rd_valid_o = rd_valid_q;
	assign rd_data_o = rd_data_q;
	assign busy_o = (state_q != ST_IDLE);
	assign full_o = !full_all_n;
	assign empty_o = !empty_all_n;
	assign half_full_o = !depth_mode && !half_full_indicator_n_i;

	// helper: length of the current write strobe low phase
	logic [CNT_W-1:0] wr_low_run_q;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) wr_low_run_q <= '0;
		else wr_low_run_q <= write_strobe_n_o ? '0 : wr_low_run_q + 1'b1;
	end

	// helper: length of the current clear pin low phase
	logic [CNT_W-1:0] clr_low_run_q;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) clr_low_run_q <= '0;
		else clr_low_run_q <= clear_input_n_o ? '0 : clr_low_run_q + 1'h1;
	end

	property p_write_guard;
		@(posedge clk_i) disable iff (rst_i)
		$fell(write_strobe_n_o) |-> $past(full_all_n);
	endproperty
	a_write_guard: assert property (p_write_guard) else $error("write strobe while full");

	property p_read_guard;
		@(posedge clk_i) disable iff (rst_i)
		$fell(read_strobe_n_o) |-> $past(empty_all_n) && !rd_valid_q;
	endproperty
	a_read_guard: assert property (p_read_guard) else $error("read strobe while empty");

	property p_clear_quiet;
		@(posedge clk_i) disable iff (rst_i)
		!clear_input_n_o |-> write_strobe_n_o && read_strobe_n_o;
	endproperty
	a_clear_quiet: assert property (p_clear_quiet) else $error("strobe during clear");

	property p_write_width;
		@(posedge clk_i) disable iff (rst_i)
		$rose(write_strobe_n_o) |-> wr_low_run_q == CNT_W'(WR_LOW_CYC);
	endproperty
	a_write_width: assert property (p_write_width) else $error("write pulse width wrong");

	property p_write_data_stable;
		@(posedge clk_i) disable iff (rst_i)
		!write_strobe_n_o |=> $stable(data_in_bus_o);
	endproperty
	a_write_data_stable: assert property (p_write_data_stable) else $error("data moved");

	property p_head_low;
		@(posedge clk_i) disable iff (rst_i)
		depth_mode && IS_FIRST |-> !chain_head_select_o;
	endproperty
	a_head_low: assert property (p_head_low) else $error("chain head not low");

	property p_head_high;
		@(posedge clk_i) disable iff (rst_i)
		depth_mode && !IS_FIRST |-> chain_head_select_o;
	endproperty
	a_head_high: assert property (p_head_high) else $error("chain member not high");

	property p_no_replay_depth;
		@(posedge clk_i) disable iff (rst_i)
		depth_mode |-> state_q != ST_REPLAY && !half_full_o;
	endproperty
	a_no_replay_depth: assert property (p_no_replay_depth) else $error("replay in depth");

	property p_read_capture;
		@(posedge clk_i) disable iff (rst_i)
		$rose(rd_valid_q) |-> $rose(read_strobe_n_o) && rd_data_q == $past(data_out_bus_i);
	endproperty
	a_read_capture: assert property (p_read_capture) else $error("read capture wrong");

	property p_pop_on_rise;
		@(posedge clk_i) disable iff (rst_i)
		(out_s.valid && out_s.ready) |=> $rose(write_strobe_n_o);
	endproperty
	a_pop_on_rise: assert property (p_pop_on_rise) else $error("pop not on strobe rise");

	property p_wr_has_word;
		@(posedge clk_i) disable iff (rst_i)
		$fell(write_strobe_n_o) |-> out_s.valid;
	endproperty
	a_wr_has_word: assert property (p_wr_has_word) else $error("strobe without word");

	property p_rd_hold;
		@(posedge clk_i) disable iff (rst_i)
		rd_valid_q && !rd_ready_i |=> rd_valid_q && $stable(rd_data_q);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read word moved");

	property p_clear_width;
		@(posedge clk_i) disable iff (rst_i)
		$rose(clear_input_n_o) |-> clr_low_run_q == CNT_W'(CLEAR_LOW_CYC);
	endproperty
	a_clear_width: assert property (p_clear_width) else $error("clear width wrong");
endmodule // fifo_host

/* fifo_host_pkg.sv */
// shared constants for the expansion-aware fifo host controller
package fifo_host_pkg;
	localparam int DATA_W = 9;
	localparam int CNT_W = 8;
	localparam int CLK_PERIOD_NS = 25;
	// strobe and recovery times; values are plain defaults for the attached part
	localparam int T_WR_LOW_NS = 25;
	localparam int T_ACCESS_NS = 20;
	localparam int T_FLAG_REC_NS = 15;
	localparam int T_CLEAR_LOW_NS = 50;
	localparam int T_REPLAY_LOW_NS = 25;
	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_WIDTH = 2'h1;
	localparam logic [1:0] MODE_DEPTH = 2'h2;
	localparam logic PIN_LOW = 1'b0;
	localparam logic PIN_HIGH = 1'b1;

	// least time rounds up to whole cycles, never below one
	function automatic int ns_to_cycles(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int WR_LOW_CYC = ns_to_cycles(T_WR_LOW_NS);
	localparam int ACCESS_CYC = ns_to_cycles(T_ACCESS_NS);
	localparam int FLAG_REC_CYC = ns_to_cycles(T_FLAG_REC_NS);
	localparam int CLEAR_LOW_CYC = ns_to_cycles(T_CLEAR_LOW_NS);
	localparam int REPLAY_LOW_CYC = ns_to_cycles(T_REPLAY_LOW_NS);
endpackage

/* tb_top.sv */
// self-checking testbench for the fifo host controller
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module tb_top;
	import fifo_host_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [1:0] mode_i = MODE_SINGLE;
	logic clear_req_i = 1'b0;
	logic replay_req_i = 1'b0;
	logic wr_valid_i = 1'b0;
	logic [DATA_W-1:0] wr_data_i = 9'h000;
	logic rd_ready_i = 1'b0;
	logic wr_ready_o, rd_valid_o, busy_o, full_o, empty_o, half_full_o;
	logic clear_input_n_o, chain_head_select_o, write_strobe_n_o, read_strobe_n_o;
	logic half_full_indicator_n_i;
	logic [DATA_W-1:0] rd_data_o, data_in_bus_o, data_out_bus_i;
	logic [1:0] full_indicator_n_i, empty_indicator_n_i;
	int n_mismatch = 0;
	int checks_done = 0;
	always #12.5 clk_i = ~clk_i;
	fifo_host #(.NDEV(2), .BUF_DEPTH(16), .IS_FIRST(1'b1)) fifo_host_inst (.clk_i(clk_i),
		.rst_i(rst_i), .mode_i(mode_i), .clear_req_i(clear_req_i), .replay_req_i(replay_req_i),
		.wr_valid_i(wr_valid_i), .wr_data_i(wr_data_i), .wr_ready_o(wr_ready_o),
		.rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .rd_ready_i(rd_ready_i),
		.busy_o(busy_o), .full_o(full_o), .empty_o(empty_o), .half_full_o(half_full_o),
		.clear_input_n_o(clear_input_n_o), .chain_head_select_o(chain_head_select_o),
		.write_strobe_n_o(write_strobe_n_o), .read_strobe_n_o(read_strobe_n_o),
		.data_in_bus_o(data_in_bus_o), .data_out_bus_i(data_out_bus_i),
		.full_indicator_n_i(full_indicator_n_i), .empty_indicator_n_i(empty_indicator_n_i),
		.half_full_indicator_n_i(half_full_indicator_n_i));
	fifo_dev_model #(.DEV_DEPTH(4)) fifo_dev_model_inst (.depth_mode_i(mode_i == MODE_DEPTH),
		.clear_input_n_i(clear_input_n_o), .chain_head_select_i(chain_head_select_o),
		.write_strobe_n_i(write_strobe_n_o), .read_strobe_n_i(read_strobe_n_o),
		.data_in_bus_i(data_in_bus_o), .data_out_bus_o(data_out_bus_i),
		.full_indicator_n_o(full_indicator_n_i), .empty_indicator_n_o(empty_indicator_n_i),
		.half_full_indicator_n_o(half_full_indicator_n_i));
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic fail_wait(input string what);
		n_mismatch++;
		$display("[ERR] %s expected done seen stuck", what);
		end_sim();
	endtask
	// idle must hold a few cycles, since idle with a pending word lasts only one
	task automatic wait_idle();
		int i;
		int q;
		q = 0;
		for (i = 0; i < 400 && q < 4; i++) begin
			@(negedge clk_i);
			q = (busy_o === 1'b0) ? q + 1 : 0;
		end
		if (q < 4) fail_wait("idle");
	endtask
	task automatic do_reset(input logic [1:0] m);
		@(posedge clk_i);
		mode_i <= m;
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		wait_idle();
	endtask
	task automatic push(input logic [8:0] w);
		int i;
		@(posedge clk_i);
		wr_valid_i <= 1'b1;
		wr_data_i <= w;
		for (i = 0; i < 200; i++) begin
			@(negedge clk_i);
			if (wr_ready_o === 1'b1) break;
		end
		if (i == 200) fail_wait("wr_ready");
		@(posedge clk_i);
		wr_valid_i <= 1'b0;
	endtask
	task automatic pop(input logic [8:0] exp);
		int i;
		@(posedge clk_i);
		rd_ready_i <= 1'b1;
		for (i = 0; i < 200; i++) begin
			@(negedge clk_i);
			if (rd_valid_o === 1'b1) break;
		end
		if (i == 200) fail_wait("rd_valid");
		`CHK("rd_data", exp, rd_data_o)
		@(posedge clk_i);
		rd_ready_i <= 1'b0;
	endtask
	task automatic pulse_req(input bit rep);
		@(posedge clk_i);
		if (rep) replay_req_i <= 1'b1;
		else clear_req_i <= 1'b1;
		@(posedge clk_i);
		replay_req_i <= 1'b0;
		clear_req_i <= 1'b0;
		wait_idle();
	endtask
	task automatic sc_reset();
		do_reset(MODE_SINGLE);
		`CHK("empty", 1'b1, empty_o)
		`CHK("full", 1'b0, full_o)
		`CHK("half_full", 1'b0, half_full_o)
		`CHK("clear_pin", 1'b1, clear_input_n_o)
	endtask
	task automatic sc_full_single();
		int k;
		for (k = 0; k < 6; k++) push(9'h100 + k[8:0]);
		wait_idle();
		`CHK("full", 1'b1, full_o)
		`CHK("half_full", 1'b1, half_full_o)
		for (k = 0; k < 6; k++) pop(9'h100 + k[8:0]);
		wait_idle();
		`CHK("empty", 1'b1, empty_o)
		`CHK("rd_valid", 1'b0, rd_valid_o)
	endtask
	task automatic sc_replay();
		// replay restarts at location zero, so the device is cleared first
		pulse_req(1'b0);
		`CHK("empty", 1'b1, empty_o)
		push(9'h0a5);
		push(9'h15a);
		pop(9'h0a5);
		pop(9'h15a);
		wait_idle();
		pulse_req(1'b1);
		pop(9'h0a5);
		pop(9'h15a);
	endtask
	task automatic sc_depth();
		int k;
		do_reset(MODE_DEPTH);
		`CHK("head_select", 1'b0, chain_head_select_o)
		for (k = 0; k < 9; k++) push(9'h040 + k[8:0]);
		wait_idle();
		`CHK("full", 1'b1, full_o)
		`CHK("half_full", 1'b0, half_full_o)
		pulse_req(1'b1);
		for (k = 0; k < 9; k++) pop(9'h040 + k[8:0]);
		push(9'h1ff);
		push(9'h001);
		wait_idle();
		pulse_req(1'b0);
		`CHK("empty", 1'b1, empty_o)
		`CHK("full", 1'b0, full_o)
	endtask
	initial begin
		sc_reset();
		sc_full_single();
		sc_replay();
		sc_depth();
		end_sim();
	end
endmodule // tb_top

/* word_buffer.sv */
// parameterised first-in first-out buffer for outgoing words
`timescale 1ns/100ps
module word_buffer #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	word_stream_if.sink push,
	word_stream_if.source pop
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	// the head word sits in its own register so the consumer only sees flop data
	logic [WIDTH-1:0] head_q;
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;

	function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : p + 1'h1;
	endfunction

	wire push_fire = push.valid && push.ready;
	wire pop_fire = pop.valid && pop.ready;
	wire [AW-1:0] wr_next = next_ptr(wr_ptr_q);
	wire [AW-1:0] rd_next = next_ptr(rd_ptr_q);
	// a word that becomes the head at once bypasses the array, whose slot is not yet written
	wire head_from_push = push_fire
		&& ((count_q == '0) || (pop_fire && count_q == (AW+1)'(1)));

	assign push.ready = (count_q != (AW+1)'(DEPTH));
	assign pop.valid = (count_q != '0);
	assign pop.data = head_q;

	always_ff @(posedge clk_i) begin
		if (push_fire) begin
			mem_q[wr_ptr_q] <= push.data;
		end
		if (head_from_push) begin
			head_q <= push.data;
		end else if (pop_fire) begin
			head_q <= mem_q[rd_next];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			if (push_fire) wr_ptr_q <= wr_next;
			if (pop_fire) rd_ptr_q <= rd_next;
			count_q <= count_q + (AW+1)'(push_fire) - (AW+1)'(pop_fire);
		end
	end
endmodule // word_buffer

/* word_stream_if.sv */
// valid/ready word stream between the controller and its buffer
`timescale 1ns/100ps
interface word_stream_if #(
	parameter int WIDTH = 9
);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink (input valid, input data, output ready);
endinterface // word_stream_if
